// *** core/xds_core.sv ***
`timescale 1ns/100ps
`default_nettype none

//////////////////////////////////////////////////////////////////////////////
module xds_core (
    input wire logic clock,
    input wire logic reset_n,
    input wire xds_pkg::xds_regbus_t reg_bus,
    output logic [7:0] reg_rdata,
    input wire logic move_req,
    input wire xds_pkg::xds_req_t move_cmd,
    output logic move_busy,
    output logic move_done,
    output logic [7:0] move_rdata,
    output logic cpu_hold,
    output logic [1:0] cpu_state,
    output xds_pkg::xds_pins_t ext_pins,
    input wire logic [7:0] ext_data_in,
    input wire logic port4_bit0_in
);
    import xds_pkg::*;

    typedef struct packed {
        logic [1:0] phase;
        xds_mode_t mode;
        logic pend;
        xds_req_t cmd;
        logic [3:0] rem;
        logic first;
        logic late;
        logic hit;
        logic waited;
        logic strobe;
        logic [15:0] addr;
        logic [7:0] rdata;
        logic done;
        logic fin;
        logic [15:0] ptr;
        logic [15:0] alt;
        logic psel;
        logic [2:0] stretch;
        logic wait_en;
        logic [7:0] p2;
        logic ta_armed;
        logic [7:0] ta_cnt;
        logic [7:0] rd_q;
        logic [1:0] wait_sync;
        logic [7:0] din_s1;
        logic [7:0] din_s2;
    } xds_state_t;

    xds_state_t st_q;
    xds_state_t st_d;
    logic strobe_on;
    logic decide;
    logic wait_seen;
    logic [1:0] end_phase;
    logic ta_open;

    // Elaboration checks on the package constants that the fixed-width logic relies on.
    if (XDS_TA_WINDOW_CYC < 1 || XDS_TA_WINDOW_CYC > 255) begin : g_ta_window_check
        $error("Timed-access window does not fit its counter.");
    end
    if (XDS_STATES_PER_CYCLE != 4) begin : g_phase_check
        $error("The two-bit phase counter serves four states per machine cycle only.");
    end
    if (XDS_STRETCH_W != 3 || XDS_STRETCH_LSB + XDS_STRETCH_W > 8) begin : g_stretch_check
        $error("Stretch field must be three bits inside the clock control byte.");
    end
    if (XDS_WAIT_EN_BIT > 7 || XDS_PSEL_BIT > 7) begin : g_bit_check
        $error("Control bit positions must lie inside a byte.");
    end

    //////////////////////////////////////////////////////////////////////////////
    // Strobe and wait decisions, all taken from registered state.

    always_comb begin
        end_phase = st_q.late ? XDS_PH_FOUR : XDS_PH_THREE;
        strobe_on = 1'b0;
        if (st_q.mode == XDS_ACCESS) begin
            strobe_on = 1'b1;
            // Stretch zero opens the strobe in state two, otherwise state three.
            if (st_q.first && (st_q.phase < (st_q.late ? XDS_PH_TWO : XDS_PH_THREE))) begin
                strobe_on = 1'b0;
            end
            // The strobe closes only in the final machine cycle.
            if (st_q.rem == 4'h1 && !st_q.hit && st_q.phase >= end_phase) begin
                strobe_on = 1'b0;
            end
        end
        // The deciding cycle is the one whose state three precedes the strobe's rise.
        decide = (st_q.mode == XDS_ACCESS) && (st_q.rem == (st_q.late ? 4'h1 : 4'h2));
        wait_seen = st_q.wait_en && !st_q.wait_sync[1];
        ta_open = st_q.ta_cnt != 8'h0;
    end

    //////////////////////////////////////////////////////////////////////////////
    // Next-state logic.

    always_comb begin
        st_d = st_q;
        st_d.done = 1'b0;
        st_d.phase = st_q.phase + 2'h1;
        st_d.strobe = strobe_on;
        st_d.wait_sync = {st_q.wait_sync[0], port4_bit0_in};
        st_d.din_s1 = ext_data_in;
        st_d.din_s2 = st_q.din_s1;

        if (move_req && st_q.mode == XDS_IDLE && !st_q.pend) begin
            st_d.pend = 1'b1;
            st_d.cmd = move_cmd;
        end

        unique case (st_q.mode)
            XDS_IDLE: begin
                if (st_q.pend && st_q.phase == XDS_PH_FOUR) begin
                    st_d.mode = XDS_FETCH;
                end
            end
            XDS_FETCH: begin
                if (st_q.phase == XDS_PH_FOUR) begin
                    st_d.mode = XDS_ACCESS;
                    st_d.rem = {1'b0, st_q.stretch} + 4'h1;
                    st_d.late = st_q.stretch == 3'h0;
                    st_d.first = 1'b1;
                    st_d.waited = 1'b0;
                    if (st_q.cmd.indirect) begin
                        st_d.addr = {st_q.p2, st_q.cmd.ri};
                    end else begin
                        st_d.addr = st_q.psel ? st_q.alt : st_q.ptr;
                    end
                end
            end
            XDS_ACCESS: begin
                if (st_q.phase == XDS_PH_THREE) begin
                    // Waits only ever add to the stretch length.
                    st_d.hit = decide && wait_seen;
                    if (decide && wait_seen) begin
                        st_d.waited = 1'b1;
                    end
                end
                if (st_q.phase == XDS_PH_FOUR) begin
                    st_d.first = 1'b0;
                    st_d.hit = 1'b0;
                    if (st_q.hit) begin
                        // A wait hit holds the count: one more machine cycle, without limit.
                    end else if (st_q.rem == 4'h1) begin
                        st_d.mode = XDS_IDLE;
                        st_d.fin = 1'b1;
                    end else begin
                        st_d.rem = st_q.rem - 4'h1;
                    end
                end
            end
            default: begin
                st_d.mode = XDS_IDLE;
            end
        endcase

        // The data synchroniser lags the pins by two clocks, so the bus value of the last
        // strobe-low state three reaches its second stage one clock after the access ends.
        // The move stays busy for that clock, which also covers the two-clock strobe at
        // stretch zero that only opens in state two.
        if (st_q.fin) begin
            st_d.fin = 1'b0;
            st_d.pend = 1'b0;
            st_d.done = 1'b1;
            if (!st_q.cmd.write) begin
                st_d.rdata = st_q.din_s2;
            end
        end

        // Timed-access window counts down after the two-key unlock.
        if (ta_open) begin
            st_d.ta_cnt = st_q.ta_cnt - 8'h1;
        end

        st_d.rd_q = 8'h0;
        if (reg_bus.rd) begin
            unique case (reg_bus.addr)
                XDS_PTR_LO_OFS: st_d.rd_q = st_q.ptr[7:0];
                XDS_PTR_HI_OFS: st_d.rd_q = st_q.ptr[15:8];
                XDS_ALT_LO_OFS: st_d.rd_q = st_q.alt[7:0];
                XDS_ALT_HI_OFS: st_d.rd_q = st_q.alt[15:8];
                XDS_PSEL_OFS: st_d.rd_q[XDS_PSEL_BIT] = st_q.psel;
                XDS_CKCTL_OFS: st_d.rd_q[XDS_STRETCH_LSB +: XDS_STRETCH_W] = st_q.stretch;
                XDS_MMAP_OFS: st_d.rd_q[XDS_WAIT_EN_BIT] = st_q.wait_en;
                XDS_STAT_OFS: begin
                    st_d.rd_q[XDS_STAT_BUSY_BIT] = st_q.mode != XDS_IDLE;
                    st_d.rd_q[XDS_STAT_WAIT_BIT] = st_q.waited;
                end
                XDS_P2_OFS: st_d.rd_q = st_q.p2;
                default: st_d.rd_q = 8'h0;
            endcase
        end

        if (reg_bus.wr) begin
            unique case (reg_bus.addr)
                XDS_PTR_LO_OFS: st_d.ptr[7:0] = reg_bus.wdata;
                XDS_PTR_HI_OFS: st_d.ptr[15:8] = reg_bus.wdata;
                XDS_ALT_LO_OFS: st_d.alt[7:0] = reg_bus.wdata;
                XDS_ALT_HI_OFS: st_d.alt[15:8] = reg_bus.wdata;
                XDS_PSEL_OFS: st_d.psel = reg_bus.wdata[XDS_PSEL_BIT];
                XDS_CKCTL_OFS: st_d.stretch = reg_bus.wdata[XDS_STRETCH_LSB +: XDS_STRETCH_W];
                XDS_MMAP_OFS: begin
                    if (ta_open) begin
                        st_d.wait_en = reg_bus.wdata[XDS_WAIT_EN_BIT];
                    end
                end
                XDS_P2_OFS: st_d.p2 = reg_bus.wdata;
                XDS_TA_OFS: begin
                    st_d.ta_armed = reg_bus.wdata == XDS_TA_KEY1;
                    if (st_q.ta_armed && reg_bus.wdata == XDS_TA_KEY2) begin
                        st_d.ta_cnt = 8'(XDS_TA_WINDOW_CYC);
                    end
                end
                default: begin
                end
            endcase
            if (reg_bus.addr != XDS_TA_OFS) begin
                st_d.ta_armed = 1'b0;
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////////
    // State register.

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            st_q <= '0;
            st_q.mode <= XDS_IDLE;
            st_q.stretch <= XDS_STRETCH_RST;
            st_q.p2 <= XDS_P2_RST;
            st_q.wait_sync <= 2'h3;
            st_q.first <= 1'b0;
        end else begin
            st_q <= st_d;
        end
    end

    //////////////////////////////////////////////////////////////////////////////
    // Outputs.

    always_comb begin
        reg_rdata = st_q.rd_q;
        move_busy = st_q.pend || st_q.mode != XDS_IDLE;
        move_done = st_q.done;
        move_rdata = st_q.rdata;
        // The processor is frozen for the extra cycles of a move, but at stretch zero only in state four of each waited cycle.
        cpu_hold = (st_q.mode == XDS_ACCESS) && !(st_q.rem == 4'h1 && !st_q.hit);
        cpu_state = st_q.phase;
        ext_pins.addr = st_q.addr;
        ext_pins.rd_n = !(st_q.strobe && !st_q.cmd.write);
        ext_pins.wr_n = !(st_q.strobe && st_q.cmd.write);
        ext_pins.data_out = st_q.cmd.wdata;
        ext_pins.data_oe_n = !((st_q.mode == XDS_ACCESS) && st_q.cmd.write);
    end

endmodule

`default_nettype wire

// *** core/xds_pkg.sv ***
`default_nettype none

package xds_pkg;

    // Register offsets on the 8-bit register port.
    localparam logic [7:0] XDS_PTR_LO_OFS = 8'h82;
    localparam logic [7:0] XDS_PTR_HI_OFS = 8'h83;
    localparam logic [7:0] XDS_ALT_LO_OFS = 8'h84;
    localparam logic [7:0] XDS_ALT_HI_OFS = 8'h85;
    localparam logic [7:0] XDS_PSEL_OFS = 8'h86;
    localparam logic [7:0] XDS_CKCTL_OFS = 8'h8E;
    localparam logic [7:0] XDS_MMAP_OFS = 8'h9C;
    localparam logic [7:0] XDS_STAT_OFS = 8'h9D;
    localparam logic [7:0] XDS_P2_OFS = 8'hA0;
    localparam logic [7:0] XDS_TA_OFS = 8'hC7;

    // Field positions.
    localparam int XDS_STRETCH_LSB = 0;
    localparam int XDS_STRETCH_W = 3;
    localparam int XDS_WAIT_EN_BIT = 7;
    localparam int XDS_PSEL_BIT = 0;
    localparam int XDS_STAT_BUSY_BIT = 0;
    localparam int XDS_STAT_WAIT_BIT = 1;

    // Reset values.
    localparam logic [2:0] XDS_STRETCH_RST = 3'h1;
    localparam logic [7:0] XDS_P2_RST = 8'hFF;

    // Timed-access unlock sequence and the window it opens.
    localparam logic [7:0] XDS_TA_KEY1 = 8'hAA;
    localparam logic [7:0] XDS_TA_KEY2 = 8'h55;
    localparam int XDS_CLOCK_MHZ = 25;
    localparam int XDS_TA_WINDOW_NS = 120;
    localparam int XDS_TA_WINDOW_CYC = (XDS_TA_WINDOW_NS * XDS_CLOCK_MHZ) / 1000;

    // Clocks per machine cycle; phase 0..3 are states one to four.
    localparam int XDS_STATES_PER_CYCLE = 4;
    localparam logic [1:0] XDS_PH_ONE = 2'h0;
    localparam logic [1:0] XDS_PH_TWO = 2'h1;
    localparam logic [1:0] XDS_PH_THREE = 2'h2;
    localparam logic [1:0] XDS_PH_FOUR = 2'h3;

    typedef enum logic [2:0] {
        XDS_IDLE = 3'h1,
        XDS_FETCH = 3'h2,
        XDS_ACCESS = 3'h4
    } xds_mode_t;

    // One external data move request from the instruction sequencer.
    typedef struct packed {
        logic write;
        logic indirect;
        logic [7:0] ri;
        logic [7:0] wdata;
    } xds_req_t;

    // External memory pins.
    typedef struct packed {
        logic [15:0] addr;
        logic rd_n;
        logic wr_n;
        logic [7:0] data_out;
        logic data_oe_n;
    } xds_pins_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } xds_regbus_t;

endpackage

`default_nettype wire

// *** bench/xds_core_monitor.sv ***
`timescale 1ns/100ps
`default_nettype none
module xds_core_monitor (
    input wire logic clock,
    input wire logic reset_n,
    input wire xds_pkg::xds_regbus_t reg_bus,
    input wire logic [7:0] reg_rdata,
    input wire logic move_req,
    input wire logic move_busy,
    input wire logic move_done,
    input wire logic cpu_hold,
    input wire logic [1:0] cpu_state,
    input wire xds_pkg::xds_pins_t ext_pins,
    input wire logic port4_bit0_in
);
    import xds_pkg::*;
    wire logic strb = ext_pins.rd_n & ext_pins.wr_n;
    logic [2:0] str_q;
    logic [7:0] len_q;
    logic saw_q;
    // Every strobe must reach the minimum width; the exact width is judged only on moves that never saw the wait pin low.
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            str_q <= XDS_STRETCH_RST;
            len_q <= 8'h00;
            saw_q <= 1'b0;
        end else begin
            if (reg_bus.wr && reg_bus.addr == XDS_CKCTL_OFS) begin
                str_q <= reg_bus.wdata[2:0];
            end
            len_q <= strb ? 8'h00 : len_q + 8'h01;
            saw_q <= (move_req && !move_busy) ? 1'b0 : saw_q | !port4_bit0_in;
        end
    end
    wire logic [7:0] min_w = (str_q == 3'h0) ? 8'h02 : {3'h0, str_q, 2'h0};
    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);
    sequence s_end; $rose(strb); endsequence
    property p_phase; reset_n |=> cpu_state == $past(cpu_state) + 2'h1; endproperty
    a_phase: assert property (p_phase) else $error("phase did not advance");
    property p_excl; !(!ext_pins.rd_n && !ext_pins.wr_n); endproperty
    a_excl: assert property (p_excl) else $error("both strobes low");
    property p_oe; !strb |-> ext_pins.data_oe_n == ext_pins.wr_n; endproperty
    a_oe: assert property (p_oe) else $error("data drive does not match the strobe");
    property p_addr; !strb |=> strb || $stable(ext_pins.addr); endproperty
    a_addr: assert property (p_addr) else $error("address moved under strobe");
    property p_minw; s_end |-> len_q >= min_w; endproperty
    a_minw: assert property (p_minw) else $error("strobe too short");
    property p_exact; s_end and !saw_q |-> len_q == min_w; endproperty
    a_exact: assert property (p_exact) else $error("strobe width wrong");
    property p_done; s_end |-> ##[0:4] move_done; endproperty
    a_done: assert property (p_done) else $error("move did not finish");
    property p_pulse; move_done |=> !move_done; endproperty
    a_pulse: assert property (p_pulse) else $error("done too long");
    property p_hold; cpu_hold |-> move_busy; endproperty
    a_hold: assert property (p_hold) else $error("hold outside a move");
    property p_psel; reg_bus.rd && reg_bus.addr == XDS_PSEL_OFS |=> reg_rdata[7:1] == 7'h00; endproperty
    a_psel: assert property (p_psel) else $error("select upper bits set");
    property p_fall; $fell(strb) |-> move_busy; endproperty
    a_fall: assert property (p_fall) else $error("strobe without a move");
endmodule
bind xds_core xds_core_monitor xds_core_monitor_inst (.clock, .reset_n, .reg_bus, .reg_rdata, .move_req,
    .move_busy, .move_done, .cpu_hold, .cpu_state, .ext_pins, .port4_bit0_in);
`default_nettype wire

// *** bench/xds_ext_mem.sv ***
`timescale 1ns/100ps
`default_nettype none
module xds_ext_mem (
    input wire logic clock,
    input wire xds_pkg::xds_pins_t pins,
    input wire logic start,
    input wire logic [7:0] wait_clks,
    output logic [7:0] data_in,
    output logic wait_n
);
    import xds_pkg::*;
    logic [7:0] mem [256];
    logic [7:0] last_q = 8'h00;
    logic [7:0] cnt_q = 8'h00;
    always @(posedge clock) begin
        cnt_q <= start ? wait_clks : (cnt_q != 8'h00 ? cnt_q - 8'h01 : 8'h00);
        if (!pins.wr_n) begin
            mem[pins.addr[7:0]] <= pins.data_out;
        end
        if (!pins.rd_n) begin
            last_q <= mem[pins.addr[7:0]];
        end
    end
    // A released bus shows the inverse of the last value, never a held copy.
    assign data_in = !pins.rd_n ? mem[pins.addr[7:0]] : ~last_q;
    assign wait_n = (cnt_q == 8'h00);
endmodule
`default_nettype wire

// *** bench/tb_top.sv ***
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import xds_pkg::*;
    logic clock = 1'b0;
    logic reset_n = 1'b0;
    xds_regbus_t reg_bus = '0;
    logic move_req = 1'b0;
    xds_req_t move_cmd = '0;
    logic start = 1'b0;
    logic [7:0] wait_clks = 8'h00;
    logic move_busy, move_done, cpu_hold, port4_bit0_in;
    logic [7:0] reg_rdata, move_rdata, ext_data_in;
    logic [1:0] cpu_state;
    xds_pins_t ext_pins;
    logic [15:0] seen;
    int err_total = 0, samples_checked = 0, cycles = 0, width, held;
    always #20 clock = ~clock;
    xds_core xds_core_inst (.clock, .reset_n, .reg_bus, .reg_rdata, .move_req, .move_cmd, .move_busy,
        .move_done, .move_rdata, .cpu_hold, .cpu_state, .ext_pins, .ext_data_in, .port4_bit0_in);
    xds_ext_mem xds_ext_mem_inst (.clock, .pins(ext_pins), .start, .wait_clks, .data_in(ext_data_in),
        .wait_n(port4_bit0_in));
    task automatic final_report;
        $display("errors %0d checks %0d", err_total, samples_checked);
        if (err_total == 0 && samples_checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_bus <= '{a, d, 1'b1, 1'b0};
        @(posedge clock);
        reg_bus.wr <= 1'b0;
    endtask
    task automatic reg_rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clock);
        reg_bus <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge clock);
        reg_bus.rd <= 1'b0;
        #1 chk(16'(reg_rdata), 16'(exp));
    endtask
    // Runs one move and measures the strobe width and the address under it.
    task automatic mv(input logic w, input logic ind, input logic [7:0] ri, input logic [7:0] wd,
                      input logic [7:0] wt);
        @(posedge clock);
        move_cmd <= '{w, ind, ri, wd};
        move_req <= 1'b1;
        start <= 1'b1;
        wait_clks <= wt;
        @(posedge clock);
        move_req <= 1'b0;
        start <= 1'b0;
        width = 0;
        held = 0;
        repeat (400) begin
            @(posedge clock);
            #1;
            if (cpu_hold) held++;
            if (!(ext_pins.rd_n && ext_pins.wr_n)) begin
                width++;
                seen = ext_pins.addr;
            end
            if (move_done) break;
        end
        chk(16'(move_done), 16'h0001);
    endtask
    task automatic t_stretch;
        reg_rd(XDS_CKCTL_OFS, 8'h01);
        reg_rd(8'h10, 8'h00);
        reg_wr(XDS_PTR_LO_OFS, 8'h40);
        reg_wr(XDS_PTR_HI_OFS, 8'h21);
        for (int s = 0; s < 8; s++) begin
            reg_wr(XDS_CKCTL_OFS, 8'(s));
            reg_rd(XDS_CKCTL_OFS, 8'(s));
            mv(1'b1, 1'b0, 8'h00, 8'(8'hA0 + s), 8'h00);
            chk(16'(width), 16'(s == 0 ? 2 : 4 * s));
            chk(16'(held), 16'(4 * s));
            mv(1'b0, 1'b0, 8'h00, 8'h00, 8'h00);
            chk(16'(move_rdata), 16'(8'hA0 + s));
            chk(seen, 16'h2140);
        end
    endtask
    task automatic t_ptr;
        reg_wr(XDS_ALT_LO_OFS, 8'h77);
        reg_wr(XDS_ALT_HI_OFS, 8'h35);
        reg_wr(XDS_PSEL_OFS, 8'hFF);
        reg_rd(XDS_PSEL_OFS, 8'h01);
        mv(1'b1, 1'b0, 8'h00, 8'h5A, 8'h00);
        chk(seen, 16'h3577);
        reg_wr(XDS_P2_OFS, 8'h12);
        mv(1'b0, 1'b1, 8'h77, 8'h00, 8'h00);
        chk(16'(move_rdata), 16'h005A);
        chk(seen, 16'h1277);
        reg_wr(XDS_PSEL_OFS, 8'h00);
        mv(1'b0, 1'b0, 8'h00, 8'h00, 8'h00);
        chk(seen, 16'h2140);
    endtask
    task automatic t_wait;
        reg_wr(XDS_CKCTL_OFS, 8'h01);
        reg_rd(XDS_MMAP_OFS, 8'h00);
        mv(1'b0, 1'b0, 8'h00, 8'h00, 8'h20);
        chk(16'(width), 16'h0004);
        reg_rd(XDS_STAT_OFS, 8'h00);
        @(posedge clock);
        reg_bus <= '{XDS_TA_OFS, XDS_TA_KEY1, 1'b1, 1'b0};
        @(posedge clock);
        reg_bus.wdata <= XDS_TA_KEY2;
        @(posedge clock);
        reg_bus <= '{XDS_MMAP_OFS, 8'h80, 1'b1, 1'b0};
        @(posedge clock);
        reg_bus.wr <= 1'b0;
        // The refused write must land after the unlock window has closed.
        repeat (XDS_TA_WINDOW_CYC) @(posedge clock);
        reg_wr(XDS_MMAP_OFS, 8'h00);
        reg_rd(XDS_MMAP_OFS, 8'h80);
        mv(1'b0, 1'b0, 8'h00, 8'h00, 8'h20);
        chk(16'(width >= 8), 16'h0001);
        chk(16'(width % 4), 16'h0000);
        chk(16'(move_rdata), 16'h00A7);
        reg_rd(XDS_STAT_OFS, 8'h02);
        mv(1'b0, 1'b0, 8'h00, 8'h00, 8'h00);
        chk(16'(width), 16'h0004);
        reg_rd(XDS_STAT_OFS, 8'h00);
    endtask
    initial begin
        repeat (12) @(posedge clock);
        reset_n <= 1'b1;
        t_stretch();
        t_ptr();
        t_wait();
        final_report();
    end
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            err_total++;
            final_report();
        end
    end
endmodule
`default_nettype wire
